/* File: shared/dtm_pkg.sv */
package dtm_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] DTM_MODE_ADDR  = 3'h0;
  localparam logic [2:0] DTM_RUN_ADDR   = 3'h1;
  localparam logic [2:0] DTM_FLOP_ADDR  = 3'h2;
  localparam logic [2:0] DTM_LCMP_ADDR  = 3'h3;
  localparam logic [2:0] DTM_UCMP_ADDR  = 3'h4;
  localparam logic [2:0] DTM_LCNT_ADDR  = 3'h5;
  localparam logic [2:0] DTM_UCNT_ADDR  = 3'h6;
  localparam logic [2:0] DTM_STAT_ADDR  = 3'h7;

  // Pair-mode field encodings
  localparam logic [1:0] DTM_PAIR_DUAL  = 2'h0;
  localparam logic [1:0] DTM_PAIR_CASC  = 2'h1;
  localparam logic [1:0] DTM_PAIR_PULSE = 2'h2;
  localparam logic [1:0] DTM_PAIR_PWM   = 2'h3;

  // PWM period select encodings
  localparam logic [1:0] DTM_PWM_P6     = 2'h1;
  localparam logic [1:0] DTM_PWM_P7     = 2'h2;
  localparam logic [1:0] DTM_PWM_P8     = 2'h3;

  // Mode register field positions
  localparam int DTM_LCLK_LSB  = 0;
  localparam int DTM_UCLK_LSB  = 2;
  localparam int DTM_PWMS_LSB  = 4;
  localparam int DTM_PAIR_LSB  = 6;

  // Run register bit positions
  localparam int DTM_LRUN_BIT  = 0;
  localparam int DTM_URUN_BIT  = 1;
  localparam int DTM_PRUN_BIT  = 2;
  localparam int DTM_DBUF_BIT  = 7;

  // Flop control bit positions
  localparam int DTM_FSRC_BIT  = 0;
  localparam int DTM_FINV_BIT  = 1;
  localparam int DTM_FCMD_LSB  = 2;

  // Flop commands
  localparam logic [1:0] DTM_FCMD_TOG = 2'h0;
  localparam logic [1:0] DTM_FCMD_SET = 2'h1;
  localparam logic [1:0] DTM_FCMD_CLR = 2'h2;

  // Reset values
  localparam logic [7:0] DTM_MODE_RST = 8'h00;
  localparam logic [7:0] DTM_RUN_RST  = 8'h00;
  localparam logic [7:0] DTM_FLOP_RST = 8'h0c;

  // Prescaler taps in system clocks
  localparam int DTM_DIV8   = 8;
  localparam int DTM_DIV32  = 32;
  localparam int DTM_DIV128 = 128;
  localparam int DTM_DIV2048 = 2048;
  localparam int DTM_PRE_W  = 11;

  // Period of the smallest PWM frame on the div8 tap
  localparam real DTM_CLK_MHZ     = 20.0;
  localparam real DTM_PWM6_US     = 25.6;
  localparam int  DTM_PWM6_CYCLES = int'(DTM_PWM6_US * DTM_CLK_MHZ);
endpackage

/* File: rtl/dtm_sync.sv */
`timescale 1ns/1ns
module dtm_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);
  logic first_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_reg <= 1'b0;
      sync_out  <= 1'b0;
    end else if (ce) begin
      first_reg <= async_in;
      sync_out  <= first_reg;
    end
  end
endmodule // dtm_sync

/* File: rtl/dtm_timer.sv */
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - Dual mode, upper clock select 00: upper counts lower match pulses.
// - Pair mode 01 joins both timers into one 16-bit interval timer.
// - 16-bit mode clocks upper counter from lower overflow, ignoring select.
// - 16-bit mode lower compare write suspends compare; upper compare write resumes.
// - 16-bit mode lower match neither pulses the lower irq nor clears the lower counter.
// - Both match in 16-bit mode: clear both, upper irq, maybe toggle flop.
// - Pulse mode toggles flop when lower counter equals either compare.
// - Pulse mode buffered lower compare loads on upper compare match.
// - Pulse polarity follows the initial state written into the flop.
// - PWM uses lower timer only; upper timer stays an 8-bit timer.
// - PWM toggles on compare match and 2^n overflow; overflow clears.
// - PWM buffered lower compare loads on 2^n overflow.
// - Clearing lower run stops and zeroes lower counter; setting resumes.
// - PWM period is 2^n input clocks; taps div8, div32, div128.
// - Pair field: 00 dual, 01 cascade, 10 pulse, 11 PWM.
// - PWM select 01, 10, 11 mean 2^6, 2^7, 2^8.
module dtm_timer
  import dtm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_clk_pin,
  output logic            timer_out_pin,
  output logic            lower_timer_irq,
  output logic            upper_timer_irq
);
  import dtm_pkg::*;

  logic [7:0] pair_mode_register_reg;
  logic [7:0] pair_run_register_reg;
  logic [7:0] output_flop_control_reg;
  logic [7:0] lower_compare_value_reg;
  logic [7:0] lower_buffer_reg;
  logic [7:0] upper_compare_value_reg;
  logic [7:0] lower_up_counter_reg;
  logic [7:0] upper_up_counter_reg;
  logic [DTM_PRE_W-1:0] prescale_reg;
  logic       output_flop_reg;
  logic       cmp_enable_reg;
  logic       ext_sync;
  logic       ext_prev_reg;
  logic       lower_tick_reg;

  wire logic [1:0] pair_mode_field    = pair_mode_register_reg[DTM_PAIR_LSB+:2];
  wire logic [1:0] pwm_period_select  = pair_mode_register_reg[DTM_PWMS_LSB+:2];
  wire logic [1:0] upper_clock_select = pair_mode_register_reg[DTM_UCLK_LSB+:2];
  wire logic [1:0] lower_clock_select = pair_mode_register_reg[DTM_LCLK_LSB+:2];
  wire logic lower_run_bit = pair_run_register_reg[DTM_LRUN_BIT];
  wire logic upper_run_bit = pair_run_register_reg[DTM_URUN_BIT];
  wire logic prescale_run  = pair_run_register_reg[DTM_PRUN_BIT];
  wire logic dbuf_enable   = pair_run_register_reg[DTM_DBUF_BIT];
  wire logic flop_src_up   = output_flop_control_reg[DTM_FSRC_BIT];
  wire logic flop_inv_en   = output_flop_control_reg[DTM_FINV_BIT];

  wire logic mode_dual  = pair_mode_field == DTM_PAIR_DUAL;
  wire logic mode_casc  = pair_mode_field == DTM_PAIR_CASC;
  wire logic mode_pulse = pair_mode_field == DTM_PAIR_PULSE;
  wire logic mode_pwm   = pair_mode_field == DTM_PAIR_PWM;

  // Prescaler taps: one-cycle strobe when the low bits roll to zero
  wire logic [DTM_PRE_W-1:0] pre_next = prescale_reg + 11'h001;
  wire logic prescale_tap_div8    = prescale_run && pre_next[2:0] == 3'h0;
  wire logic prescale_tap_div32   = prescale_run && pre_next[4:0] == 5'h00;
  wire logic prescale_tap_div128  = prescale_run && pre_next[6:0] == 7'h00;
  wire logic prescale_tap_div2048 = prescale_run && pre_next == 11'h000;

  wire logic ext_edge = ext_sync && !ext_prev_reg;

  // Lower clock: 00 external, 01 div8, 10 div32, 11 div128
  wire logic lower_clk_en =
    lower_clock_select == 2'h0 ? ext_edge :
    lower_clock_select == 2'h1 ? prescale_tap_div8 :
    lower_clock_select == 2'h2 ? prescale_tap_div32 : prescale_tap_div128;

  wire logic lower_step = lower_run_bit && lower_clk_en;

  // Compare detection is qualified by the count edge so a match pulses once
  wire logic lower_eq  = lower_up_counter_reg == lower_compare_value_reg;
  wire logic upper_eq  = upper_up_counter_reg == upper_compare_value_reg;
  wire logic lower_hit = lower_tick_reg && lower_eq && cmp_enable_reg;
  // Pulse mode compares the lower counter against the upper compare
  wire logic lower_vs_up = lower_up_counter_reg == upper_compare_value_reg;
  wire logic pulse_top  = lower_tick_reg && mode_pulse && upper_run_bit &&
                          lower_vs_up && cmp_enable_reg;

  // PWM overflow at 2^n
  wire logic [7:0] pwm_mask =
    pwm_period_select == DTM_PWM_P6 ? 8'h3f :
    pwm_period_select == DTM_PWM_P7 ? 8'h7f : 8'hff;
  wire logic pwm_ovf = lower_step && mode_pwm &&
                       (lower_up_counter_reg & pwm_mask) == pwm_mask;

  wire logic lower_ovf = lower_step && lower_up_counter_reg == 8'hff;

  // Upper clock
  wire logic upper_clk_sel =
    upper_clock_select == 2'h0 ? lower_hit :
    upper_clock_select == 2'h1 ? prescale_tap_div8 :
    upper_clock_select == 2'h2 ? prescale_tap_div128 : prescale_tap_div2048;
  wire logic upper_step = upper_run_bit &&
    (mode_casc ? lower_ovf : upper_clk_sel) && !mode_pulse;

  logic upper_tick_reg;
  wire logic upper_hit = upper_tick_reg && upper_eq && cmp_enable_reg;
  wire logic casc_hit  = mode_casc && lower_hit && upper_hit;

  // Counter clearing per mode
  wire logic lower_clr_match = (mode_dual && lower_hit) || casc_hit ||
                               pulse_top;
  wire logic upper_clr_match = ((mode_dual || mode_pwm) && upper_hit) ||
                               casc_hit;

  // Flop toggle sources
  wire logic lower_evt = mode_pulse ? (lower_hit || pulse_top) :
                         mode_pwm   ? (lower_hit || pwm_ovf) :
                         mode_casc  ? casc_hit : lower_hit;
  wire logic flop_evt  = mode_dual && flop_src_up ? upper_hit : lower_evt;
  wire logic flop_toggle = flop_inv_en && flop_evt;

  wire logic buf_load = dbuf_enable &&
    ((mode_pulse && pulse_top) || (mode_pwm && pwm_ovf));

  wire logic wr_mode = reg_wr && reg_addr == DTM_MODE_ADDR;
  wire logic wr_run  = reg_wr && reg_addr == DTM_RUN_ADDR;
  wire logic wr_flop = reg_wr && reg_addr == DTM_FLOP_ADDR;
  wire logic wr_lcmp = reg_wr && reg_addr == DTM_LCMP_ADDR;
  wire logic wr_ucmp = reg_wr && reg_addr == DTM_UCMP_ADDR;
  wire logic [1:0] flop_cmd = reg_wdata[DTM_FCMD_LSB+:2];

  wire logic [7:0] rd_mux =
    reg_addr == DTM_MODE_ADDR ? pair_mode_register_reg :
    reg_addr == DTM_RUN_ADDR  ? pair_run_register_reg :
    reg_addr == DTM_FLOP_ADDR ? {7'h00, output_flop_reg} :
    reg_addr == DTM_LCMP_ADDR ? lower_compare_value_reg :
    reg_addr == DTM_UCMP_ADDR ? upper_compare_value_reg :
    reg_addr == DTM_LCNT_ADDR ? lower_up_counter_reg :
    reg_addr == DTM_UCNT_ADDR ? upper_up_counter_reg :
    {6'h00, cmp_enable_reg, output_flop_reg};

  dtm_sync u_ext_sync (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .async_in (ext_clk_pin),
    .sync_out (ext_sync)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pair_mode_register_reg  <= DTM_MODE_RST;
      pair_run_register_reg   <= DTM_RUN_RST;
      output_flop_control_reg <= DTM_FLOP_RST;
    end else if (ce) begin
      if (wr_mode) pair_mode_register_reg <= reg_wdata;
      if (wr_run) pair_run_register_reg <= reg_wdata;
      if (wr_flop) output_flop_control_reg <= reg_wdata;
    end
  end

  // Compare registers; a write into the lower one with the buffer enabled
  // only fills the buffer so a running waveform is not torn mid-period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lower_compare_value_reg <= 8'h00;
      lower_buffer_reg        <= 8'h00;
      upper_compare_value_reg <= 8'h00;
      cmp_enable_reg          <= 1'b1;
    end else if (ce) begin
      if (wr_lcmp) lower_buffer_reg <= reg_wdata;
      if (wr_lcmp && !dbuf_enable) lower_compare_value_reg <= reg_wdata;
      else if (buf_load) lower_compare_value_reg <= lower_buffer_reg;
      if (wr_ucmp) upper_compare_value_reg <= reg_wdata;
      if (wr_ucmp) cmp_enable_reg <= 1'b1;
      else if (wr_lcmp && mode_casc) cmp_enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prescale_reg <= 11'h000;
      ext_prev_reg <= 1'b0;
    end else if (ce) begin
      prescale_reg <= prescale_run ? pre_next : 11'h000;
      ext_prev_reg <= ext_sync;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lower_up_counter_reg <= 8'h00;
      lower_tick_reg       <= 1'b0;
    end else if (ce) begin
      lower_tick_reg <= lower_step;
      if (!lower_run_bit) lower_up_counter_reg <= 8'h00;
      else if (lower_clr_match || pwm_ovf)
        lower_up_counter_reg <= 8'h00;
      else if (lower_step)
        lower_up_counter_reg <= lower_up_counter_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_up_counter_reg <= 8'h00;
      upper_tick_reg       <= 1'b0;
    end else if (ce) begin
      // Cascade compares both halves in the same cycle, so the upper tick
      // follows the lower step rather than the delayed lower tick
      upper_tick_reg <= upper_step || (mode_casc && lower_step);
      if (!upper_run_bit) upper_up_counter_reg <= 8'h00;
      else if (upper_clr_match) upper_up_counter_reg <= 8'h00;
      else if (upper_step)
        upper_up_counter_reg <= upper_up_counter_reg + 8'h01;
    end
  end

  // Flop: software command wins over a same-cycle toggle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_flop_reg <= 1'b0;
      timer_out_pin   <= 1'b0;
    end else if (ce) begin
      if (wr_flop && flop_cmd == DTM_FCMD_SET) output_flop_reg <= 1'b1;
      else if (wr_flop && flop_cmd == DTM_FCMD_CLR) output_flop_reg <= 1'b0;
      else if (wr_flop && flop_cmd == DTM_FCMD_TOG)
        output_flop_reg <= !output_flop_reg;
      else if (flop_toggle) output_flop_reg <= !output_flop_reg;
      timer_out_pin <= output_flop_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lower_timer_irq <= 1'b0;
      upper_timer_irq <= 1'b0;
      reg_rdata       <= 8'h00;
    end else if (ce) begin
      lower_timer_irq <= mode_pwm ? pwm_ovf : (!mode_casc && lower_evt);
      upper_timer_irq <= mode_casc ? casc_hit :
                         (!mode_pulse && upper_hit);
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end
endmodule // dtm_timer

/* File: tb/dtm_timer_assertions.sv */
`timescale 1ns/1ns
module dtm_assertions
  import dtm_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ce,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       timer_out_pin,
  input wire logic       lower_timer_irq,
  input wire logic       upper_timer_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire flop_wr = reg_wr && ce && reg_addr == DTM_FLOP_ADDR;
  sequence set_wr;
    flop_wr && reg_wdata[3:2] == DTM_FCMD_SET;
  endsequence
  sequence clr_wr;
    flop_wr && reg_wdata[3:2] == DTM_FCMD_CLR;
  endsequence
  sequence stop_wr;
    reg_wr && ce && reg_addr == DTM_RUN_ADDR && !reg_wdata[DTM_LRUN_BIT];
  endsequence
  sequence cnt_rd;
    reg_rd && ce && !reg_wr && reg_addr == DTM_LCNT_ADDR;
  endsequence
  a_rdata_idle_zero: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_freeze_on_ce: assert property (!ce |=> $stable({timer_out_pin,
    lower_timer_irq, upper_timer_irq, reg_rdata}))
    else $error("outputs moved while clock enable low");
  a_flop_set_cmd: assert property (set_wr ##1 ce |=> timer_out_pin)
    else $error("set command did not raise output");
  a_flop_clr_cmd: assert property (clr_wr ##1 ce |=> !timer_out_pin)
    else $error("clear command did not lower output");
  a_status_flop_bit: assert property (reg_rd && ce && reg_addr == DTM_STAT_ADDR
    |=> reg_rdata[0] == timer_out_pin)
    else $error("status flop bit differs from output pin");
  a_stop_clears_count: assert property (stop_wr ##1 (ce && !reg_wr) ##1 cnt_rd
    |=> reg_rdata == 8'h00)
    else $error("stopped lower counter not zero");
  a_lower_irq_pulse: assert property (lower_timer_irq && ce
    |=> !lower_timer_irq)
    else $error("lower interrupt longer than one cycle");
  a_upper_irq_pulse: assert property (upper_timer_irq && ce
    |=> !upper_timer_irq)
    else $error("upper interrupt longer than one cycle");
endmodule // dtm_assertions

bind dtm_timer dtm_assertions u_chk (.clk(clk), .resetn(resetn), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_out_pin(timer_out_pin),
  .lower_timer_irq(lower_timer_irq), .upper_timer_irq(upper_timer_irq));

/* File: tb/dtm_timer_bench.sv */
`timescale 1ns/1ns
module dtm_timer_bench;
  import dtm_pkg::*;
  logic       clk = 1'b0, resetn = 1'b0, ce = 1'b1, ext_clk_pin = 1'b0;
  logic       reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, n_lirq = 8'h00, n_uirq = 8'h00;
  logic       timer_out_pin, lower_timer_irq, upper_timer_irq;
  logic [1:0] sel [3] = '{DTM_PWM_P6, DTM_PWM_P7, DTM_PWM_P8};
  int         n_errors = 0, total_checks = 0;
  int         gap_n;
  logic [7:0] mark;
  dtm_timer dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk_pin),
    .timer_out_pin(timer_out_pin), .lower_timer_irq(lower_timer_irq),
    .upper_timer_irq(upper_timer_irq));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (lower_timer_irq === 1'b1) n_lirq <= n_lirq + 8'h01;
    if (upper_timer_irq === 1'b1) n_uirq <= n_uirq + 8'h01;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Ext pin is synchronised, so each level is held two cycles
  task automatic edges(input int k);
    repeat (k) begin
      @(posedge clk);
      ext_clk_pin <= 1'b1;
      repeat (2) @(posedge clk);
      ext_clk_pin <= 1'b0;
      @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic pin(input logic exp);
    chk({7'h00, timer_out_pin}, {7'h00, exp});
  endtask
  // Cycles from one lower interrupt to the next, both waits bounded
  task automatic irq_gap(output int n);
    int k;
    k = 0;
    n = 0;
    while (lower_timer_irq !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (lower_timer_irq !== 1'b1 && n < 2000);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(DTM_MODE_ADDR, DTM_MODE_RST);
    rd(DTM_RUN_ADDR, DTM_RUN_RST);
    rd(DTM_STAT_ADDR, 8'h02);
    wr(DTM_LCMP_ADDR, 8'h03);
    wr(DTM_UCMP_ADDR, 8'h02);
    wr(DTM_RUN_ADDR, 8'h03);
    edges(4);
    chk(n_lirq, 8'h01);
    rd(DTM_UCNT_ADDR, 8'h01);
    wr(DTM_RUN_ADDR, 8'h00);
    rd(DTM_LCNT_ADDR, 8'h00);
    wr(DTM_RUN_ADDR, 8'h01);
    edges(1);
    rd(DTM_LCNT_ADDR, 8'h01);
    wr(DTM_RUN_ADDR, 8'h00);
    wr(DTM_MODE_ADDR, {DTM_PAIR_CASC, 6'h00});
    wr(DTM_FLOP_ADDR, 8'h0a);
    wr(DTM_LCMP_ADDR, 8'h02);
    rd(DTM_STAT_ADDR, 8'h00);
    wr(DTM_UCMP_ADDR, 8'h01);
    rd(DTM_STAT_ADDR, 8'h02);
    wr(DTM_RUN_ADDR, 8'h03);
    edges(3);
    rd(DTM_LCNT_ADDR, 8'h03);
    rd(DTM_UCNT_ADDR, 8'h00);
    chk(n_uirq, 8'h00);
    edges(255);
    chk(n_uirq, 8'h01);
    pin(1'b1);
    rd(DTM_UCNT_ADDR, 8'h00);
    wr(DTM_RUN_ADDR, 8'h00);
    wr(DTM_MODE_ADDR, {DTM_PAIR_PULSE, 6'h00});
    wr(DTM_FLOP_ADDR, 8'h06);
    wr(DTM_LCMP_ADDR, 8'h02);
    wr(DTM_UCMP_ADDR, 8'h04);
    wr(DTM_RUN_ADDR, 8'h03);
    edges(0);
    pin(1'b1);
    edges(2);
    pin(1'b0);
    edges(2);
    pin(1'b1);
    rd(DTM_LCNT_ADDR, 8'h00);
    wr(DTM_RUN_ADDR, 8'h83);
    wr(DTM_LCMP_ADDR, 8'h01);
    rd(DTM_LCMP_ADDR, 8'h02);
    edges(4);
    rd(DTM_LCMP_ADDR, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(DTM_RUN_ADDR, 8'h00);
      wr(DTM_MODE_ADDR, {DTM_PAIR_PWM, sel[i], 4'h0});
      wr(DTM_LCMP_ADDR, 8'h03);
      wr(DTM_FLOP_ADDR, 8'h0a);
      wr(DTM_RUN_ADDR, 8'h01);
      mark = n_lirq;
      edges(3);
      pin(1'b1);
      edges((1 << (i + 6)) - 4);
      chk(n_lirq - mark, 8'h00);
      edges(1);
      chk(n_lirq - mark, 8'h01);
      pin(1'b0);
      rd(DTM_LCNT_ADDR, 8'h00);
    end
    // Pin edges seen only while enabled, so a frozen block counts nothing
    @(posedge clk);
    ce <= 1'b0;
    edges(2);
    ce <= 1'b1;
    rd(DTM_LCNT_ADDR, 8'h00);
    // Prescaled PWM: period from the div8 tap, buffered compare on overflow
    wr(DTM_RUN_ADDR, 8'h00);
    wr(DTM_MODE_ADDR, {DTM_PAIR_PWM, DTM_PWM_P6, 4'h1});
    wr(DTM_LCMP_ADDR, 8'h03);
    wr(DTM_RUN_ADDR, 8'h85);
    wr(DTM_LCMP_ADDR, 8'h05);
    rd(DTM_LCMP_ADDR, 8'h03);
    irq_gap(gap_n);
    chk(8'(gap_n >> 8), 8'(DTM_PWM6_CYCLES >> 8));
    chk(8'(gap_n), 8'(DTM_PWM6_CYCLES));
    rd(DTM_LCMP_ADDR, 8'h05);
    end_of_test;
  end
endmodule // dtm_timer_bench
